//--- pkg/evt_unit_cfg.svh
`ifndef EVT_UNIT_CFG_SVH
`define EVT_UNIT_CFG_SVH
// register byte offsets
`define OFS_SR 12'h000
`define OFS_EVB 12'h004
`define OFS_SSP 12'h008
`define OFS_DRSR 12'h00C
`define OFS_DRAR 12'h010
`define OFS_CAUSE 12'h014
// status register fields
`define SR_GM 16
`define SR_IM0 17
`define SR_EM 21
`define SR_MODE_LO 22
`define SR_MODE_HI 24
`define SR_DM 26
`define SR_DF 27
`define SR_MODE_MSK 32'h01C0_0000
`define SR_DF_MSK 32'h0800_0000
// reset values
`define SR_RST 32'h0061_0000
`define EVB_RST 32'h0000_0000
`define SSP_RST 32'h0000_0000
// event vector layout
`define EV_NUM 10
`define EV_FIXED 4'd5
`define EV_EXC 4'd9
`define SCALL_OFS 14'h0100
`define WORDS_BASE 4'h2
`define WORDS_INT 4'h8
`endif

//--- pkg/evt_unit_pkg.sv
package evt_unit_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_POP = 2'b10
    } fsm_t;
    typedef enum logic [2:0] {
        MODE_APP = 3'b000,
        MODE_SUP = 3'b001,
        MODE_INTERRUPT_LEVEL0 = 3'b010,
        MODE_INTERRUPT_LEVEL1 = 3'b011,
        MODE_INTERRUPT_LEVEL2 = 3'b100,
        MODE_INTERRUPT_LEVEL3 = 3'b101,
        MODE_EXC = 3'b110,
        MODE_NMI = 3'b111
    } mode_t;
endpackage

//--- rtl/evt_prio_pick.sv
`timescale 1ns/10ps
`include "evt_unit_cfg.svh"
module evt_prio_pick
(
    // eligible requests, bit 0 most urgent
    input wire logic [`EV_NUM-1:0] req,
    // winner
    output logic [3:0] idx,
    output logic any
);
    always_comb
    begin
        idx = 4'h0;
        any = 1'b0;
        // downward scan so the lowest set bit wins
        for (int i = `EV_NUM - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = 4'(i);
                any = 1'b1;
            end
        end
    end
endmodule

//--- rtl/ctx_stack_seq.sv
`timescale 1ns/10ps
module ctx_stack_seq
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    input wire logic pop,
    input wire logic [3:0] nwords,
    input wire logic [31:0] sp,
    input wire logic ack,
    // progress
    output logic busy,
    output logic [2:0] idx,
    output logic [31:0] addr,
    output logic done,
    output logic [31:0] sp_next
);
    logic busy_q;
    logic pop_q;
    logic [3:0] cnt_q;
    logic [3:0] n_q;
    logic last;

    assign last = (cnt_q == n_q - 4'h1);
    assign busy = busy_q;
    assign done = busy_q & ack & last;
    // pops walk the words back in reverse order
    assign idx = pop_q ? 3'(n_q - 4'h1 - cnt_q) : cnt_q[2:0];
    assign addr = pop_q ? sp + {26'h0, cnt_q, 2'b00} : sp - {26'h0, cnt_q + 4'h1, 2'b00};
    assign sp_next = pop_q ? sp + {26'h0, n_q, 2'b00} : sp - {26'h0, n_q, 2'b00};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            pop_q <= 1'b0;
            cnt_q <= 4'h0;
            n_q <= 4'h1;
        end
        else if (start)
        begin
            busy_q <= 1'b1;
            pop_q <= pop;
            cnt_q <= 4'h0;
            n_q <= nwords;
        end
        else if (busy_q & ack)
        begin
            busy_q <= ~last;
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

//--- rtl/evt_unit.sv
`timescale 1ns/10ps
`include "evt_unit_cfg.svh"
module evt_unit
    import evt_unit_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources
    input wire logic unrec_req,
    input wire logic multihit_req,
    input wire logic bus_err_d_req,
    input wire logic bus_err_i_req,
    input wire logic nmi_req,
    input wire logic [3:0] int_req,
    input wire logic [13:0] ivec_offset,
    input wire logic exc_old_req,
    input wire logic [13:0] exc_old_offset,
    input wire logic exc_young_req,
    input wire logic [13:0] exc_young_offset,
    output logic [`EV_NUM-1:0] ev_ack,
    // core instructions and context
    input wire logic scall_req,
    input wire logic rete_req,
    input wire logic rets_req,
    input wire logic retd_req,
    input wire logic dbg_req,
    input wire logic [31:0] dbg_vector,
    input wire logic [31:0] ctx_pc,
    input wire logic [31:0] gpr_in [6],
    output logic op_ack,
    output logic core_stall,
    output logic pc_load,
    output logic [31:0] pc_out,
    output logic gpr_load,
    output logic [31:0] gpr_out [6],
    output logic [2:0] bank_sel,
    output logic [31:0] sr_out,
    // system stack port
    output logic stk_req,
    output logic stk_we,
    output logic [31:0] stk_addr,
    output logic [31:0] stk_wdata,
    input wire logic stk_ack,
    input wire logic [31:0] stk_rdata
);
    fsm_t st_q;
    fsm_t st_d;
    logic [31:0] sr_q;
    logic [31:0] event_vector_base_q;
    logic [31:0] ssp_q;
    logic [31:0] drsr_q;
    logic [31:0] drar_q;
    logic [31:0] nsr_q;
    logic [31:0] tgt_q;
    logic [31:0] ret_pc_q;
    logic [3:0] nwords_q;
    logic [3:0] last_idx_q;
    logic [31:0] pop_w_q [8];
    logic pc_load_q;
    logic [31:0] pc_out_q;
    logic gpr_load_q;
    logic [31:0] prdata_q;
    logic hit_q;

    function automatic logic [31:0] vec_or(input logic [31:0] base, input logic [13:0] ofs);
        return base | {18'h0, ofs};
    endfunction

    function automatic logic [31:0] sr_accept(input logic [31:0] sr, input logic [3:0] idx);
        logic [31:0] s;
        s = sr;
        if (idx < `EV_FIXED || idx == `EV_EXC)
        begin
            s[`SR_EM] = 1'b1;
            s[`SR_GM] = 1'b1;
        end
        for (int j = 0; j < 4; j++)
        begin
            if (idx < `EV_FIXED || 4'(j) <= (4'd8 - idx))
                s[`SR_IM0 + j] = (idx == `EV_EXC) ? s[`SR_IM0 + j] : 1'b1;
        end
        if (idx == 4'd4)
            s[`SR_MODE_HI:`SR_MODE_LO] = MODE_NMI;
        else if (idx < `EV_FIXED || idx == `EV_EXC)
            s[`SR_MODE_HI:`SR_MODE_LO] = MODE_EXC;
        else
            s[`SR_MODE_HI:`SR_MODE_LO] = 3'(MODE_INTERRUPT_LEVEL0 + 3'(4'd8 - idx));
        return s;
    endfunction

    // status fields
    wire sr_gm = sr_q[`SR_GM];
    wire sr_em = sr_q[`SR_EM];
    wire sr_dm = sr_q[`SR_DM];
    wire sr_df = sr_q[`SR_DF];
    wire [3:0] ilm = sr_q[`SR_IM0+3:`SR_IM0];
    wire [2:0] cur_mode = sr_q[`SR_MODE_HI:`SR_MODE_LO];
    wire cur_int = (cur_mode >= MODE_INTERRUPT_LEVEL0) && (cur_mode <= MODE_INTERRUPT_LEVEL3);

    wire [13:0] exc_ofs = exc_old_req ? exc_old_offset : exc_young_offset;
    wire exc_any = exc_old_req | exc_young_req;

    wire [`EV_NUM-1:0] raw_req = {exc_any, int_req[0], int_req[1], int_req[2], int_req[3],
                                  nmi_req, bus_err_i_req, bus_err_d_req, multihit_req, unrec_req};
    // an interrupt masks only equal or lower levels, so higher levels preempt
    wire [`EV_NUM-1:0] unmask = {~sr_em, ~sr_gm & ~ilm[0], ~sr_gm & ~ilm[1],
                                 ~sr_gm & ~ilm[2], ~sr_gm & ~ilm[3], 5'h1F};
    wire [`EV_NUM-1:0] elig = raw_req & unmask;
    logic [3:0] win_idx;
    logic win_any;

    evt_prio_pick u_pick
    (
        .req(elig),
        .idx(win_idx),
        .any(win_any)
    );

    // request arbitration, debug stop ranks first
    wire idle = (st_q == ST_IDLE);
    wire dbg_go = idle & dbg_req & ~sr_dm & ~sr_df;
    wire ev_go = idle & ~dbg_go & win_any;
    wire free1 = idle & ~dbg_go & ~win_any;
    wire retd_go = free1 & sr_df & retd_req;
    wire sc_go = free1 & ~retd_go & scall_req;
    wire rete_go = free1 & ~retd_go & ~scall_req & rete_req;
    wire rets_go = free1 & ~retd_go & ~scall_req & ~rete_req & rets_req;
    wire push_go = ev_go | sc_go;
    wire pop_go = rete_go | rets_go;
    wire ev_is_int = (win_idx >= `EV_FIXED) && (win_idx < `EV_EXC);

    wire [13:0] ev_ofs = (win_idx < `EV_FIXED) ? {8'h00, win_idx, 2'b00} :
                         (win_idx == `EV_EXC) ? exc_ofs : ivec_offset;
    // supervisor call entry on a wide slot
    wire [13:0] push_ofs = ev_go ? ev_ofs : `SCALL_OFS;
    wire [31:0] push_tgt = vec_or(event_vector_base_q, push_ofs);
    wire [31:0] sc_sr = (sr_q & ~`SR_MODE_MSK) | {7'h0, MODE_SUP, 22'h0};
    wire [31:0] push_sr = ev_go ? sr_accept(sr_q, win_idx) : sc_sr;
    // six more words for interrupt levels
    wire [3:0] push_n = (ev_go && ev_is_int) ? `WORDS_INT : `WORDS_BASE;
    // pop six more words out of an interrupt level
    wire [3:0] pop_n = (rete_go && cur_int) ? `WORDS_INT : `WORDS_BASE;
    // debug flag raised on entry
    // flag at 27, mode at 24:22, level masks at 20:17; exception mask kept
    wire [31:0] dbg_sr = (sr_q & ~`SR_MODE_MSK) | {4'h0, 1'b1, 2'h0, MODE_EXC, 1'b0, 4'hF, 17'h0};

    logic seq_busy;
    logic [2:0] seq_idx;
    logic [31:0] seq_addr;
    logic seq_done;
    logic [31:0] seq_sp;

    // stack walk for status and pc
    ctx_stack_seq u_seq
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(push_go | pop_go),
        .pop(pop_go),
        .nwords(push_go ? push_n : pop_n),
        .sp(ssp_q),
        .ack(stk_ack),
        .busy(seq_busy),
        .idx(seq_idx),
        .addr(seq_addr),
        .done(seq_done),
        .sp_next(seq_sp)
    );

    // word 0 status, 1 return pc, 2..7 r8..r12 and link
    wire [2:0] gpr_idx = 3'(seq_idx - 3'd2);
    wire [31:0] push_word = (seq_idx == 3'd0) ? sr_q : (seq_idx == 3'd1) ? ret_pc_q : gpr_in[gpr_idx];
    wire push_end = seq_done & (st_q == ST_PUSH);
    wire pop_end = seq_done & (st_q == ST_POP);

    assign st_d = push_go ? ST_PUSH : pop_go ? ST_POP : seq_done ? ST_IDLE : st_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= ST_IDLE;
            nsr_q <= 32'h0000_0000;
            tgt_q <= 32'h0000_0000;
            ret_pc_q <= 32'h0000_0000;
            nwords_q <= `WORDS_BASE;
            last_idx_q <= 4'h0;
        end
        else
        begin
            st_q <= st_d;
            if (push_go)
            begin
                nsr_q <= push_sr;
                tgt_q <= push_tgt;
                ret_pc_q <= ctx_pc;
                nwords_q <= push_n;
            end
            else if (pop_go)
                nwords_q <= pop_n;
            if (ev_go)
                last_idx_q <= win_idx;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (seq_busy && stk_ack && st_q == ST_POP)
            pop_w_q[seq_idx] <= stk_rdata;
    end

    // apb decode
    wire apb_wr = psel & penable & pwrite;
    wire sel_sr = (paddr == `OFS_SR);
    wire sel_evb = (paddr == `OFS_EVB);
    wire sel_ssp = (paddr == `OFS_SSP);
    wire sel_drsr = (paddr == `OFS_DRSR);
    wire sel_drar = (paddr == `OFS_DRAR);
    wire sel_cause = (paddr == `OFS_CAUSE);
    wire addr_hit = sel_sr | sel_evb | sel_ssp | sel_drsr | sel_drar | sel_cause;
    wire [31:0] cause_val = {26'h0, st_q, last_idx_q};
    wire [31:0] rd_mux = sel_sr ? sr_q : sel_evb ? event_vector_base_q : sel_ssp ? ssp_q : sel_drsr ? drsr_q :
                         sel_drar ? drar_q : sel_cause ? cause_val : 32'h0000_0000;
    // mode bits writable only in debug mode
    wire [31:0] sr_keep = sr_df ? `SR_DF_MSK : (`SR_DF_MSK | `SR_MODE_MSK);
    wire [31:0] sr_wval = (pwdata & ~sr_keep) | (sr_q & sr_keep);

    // hardware updates win over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sr_q <= `SR_RST;
        else if (dbg_go)
            sr_q <= dbg_sr;
        else if (retd_go)
            sr_q <= drsr_q;
        // mode and masks take effect after save
        else if (push_end)
            sr_q <= nsr_q;
        else if (pop_end)
            sr_q <= stk_rdata;
        else if (apb_wr && sel_sr)
            sr_q <= sr_wval;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_vector_base_q <= `EVB_RST;
            ssp_q <= `SSP_RST;
            drsr_q <= 32'h0000_0000;
            drar_q <= 32'h0000_0000;
        end
        else
        begin
            if (apb_wr && sel_evb)
                event_vector_base_q <= pwdata;
            if (seq_done)
                ssp_q <= seq_sp;
            else if (apb_wr && sel_ssp)
                ssp_q <= pwdata;
            // debug context kept off the stack
            if (dbg_go)
            begin
                drsr_q <= sr_q;
                drar_q <= ctx_pc;
            end
            else
            begin
                if (apb_wr && sel_drsr)
                    drsr_q <= pwdata;
                if (apb_wr && sel_drar)
                    drar_q <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_load_q <= 1'b0;
            pc_out_q <= 32'h0000_0000;
            gpr_load_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end
        else
        begin
            pc_load_q <= dbg_go | retd_go | seq_done;
            if (dbg_go)
                pc_out_q <= dbg_vector;
            else if (retd_go)
                pc_out_q <= drar_q;
            else if (push_end)
                pc_out_q <= tgt_q;
            else if (pop_end)
                pc_out_q <= pop_w_q[1];
            gpr_load_q <= pop_end & (nwords_q == `WORDS_INT);
            // read data captured in the setup cycle, zero wait access
            if (psel && !penable)
            begin
                prdata_q <= rd_mux;
                hit_q <= addr_hit;
            end
        end
    end

    // ack tells the holding source it was taken
    assign ev_ack = ev_go ? (`EV_NUM'(1) << win_idx) : '0;
    assign op_ack = sc_go | rete_go | rets_go | retd_go | dbg_go;
    assign core_stall = ~idle;
    assign pc_load = pc_load_q;
    assign pc_out = pc_out_q;
    assign gpr_load = gpr_load_q;
    for (genvar g = 0; g < 6; g++)
    begin : g_gpr
        assign gpr_out[g] = pop_w_q[g + 2];
    end
    assign bank_sel = cur_mode;
    assign sr_out = sr_q;
    assign stk_req = seq_busy;
    assign stk_we = seq_busy & (st_q == ST_PUSH);
    assign stk_addr = seq_addr;
    assign stk_wdata = push_word;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_q;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    or_target_a: assert property (push_end |=> pc_load && pc_out == $past(tgt_q))
        else $error("pc not loaded with handler target");
    or_bits_a: assert property (ev_go |=> (tgt_q & ~$past(event_vector_base_q) & ~{18'h0, $past(ev_ofs)}) == 32'h0)
        else $error("handler target not an or of base and offset");
    mask_gate_a: assert property (ev_go |-> unmask[win_idx])
        else $error("masked event accepted");
    crit_take_a: assert property (idle && !dbg_go && unrec_req |-> ev_ack == `EV_NUM'(1))
        else $error("unmaskable event not taken");
    int_mask_a: assert property (ev_go && win_idx == 4'd5 |=> nsr_q[`SR_IM0+3:`SR_IM0] == 4'hF)
        else $error("level masks not raised");
    exc_mask_a: assert property (ev_go && win_idx == `EV_EXC |=> nsr_q[`SR_EM] && nsr_q[`SR_GM])
        else $error("exception masks not raised");
    atomic_hold_a: assert property (push_go |=> core_stall && ev_ack == '0)
        else $error("event taken during save");
    int_words_a: assert property (ev_go && ev_is_int |=> nwords_q == `WORDS_INT)
        else $error("interrupt save count wrong");
    dbg_entry_a: assert property (dbg_go |=> sr_df && ilm == 4'hF ##0 pc_load && pc_out == $past(dbg_vector))
        else $error("debug entry incomplete");
    dbg_block_a: assert property (idle && dbg_req && sr_dm && !sr_df |=> !sr_df)
        else $error("masked debug request entered");
    pop_restore_a: assert property (pop_end |=> sr_q == $past(stk_rdata) && pc_load)
        else $error("return did not restore status");
    one_ack_a: assert property ($onehot0(ev_ack))
        else $error("more than one event accepted");
    old_first_a: assert property (exc_old_req |-> exc_ofs == exc_old_offset)
        else $error("younger event chosen first");
    int_take_c: cover property (ev_go && ev_is_int ##[1:40] push_end);
    dbg_round_c: cover property (dbg_go ##[1:50] retd_go);
    rete_c: cover property (rete_go ##[1:40] pop_end && nwords_q == `WORDS_INT);
endmodule

//--- dv/stack_mem.sv
`timescale 1ns/10ps
module stack_mem
(
    // clock and pace
    input wire logic pclk,
    input wire logic slow,
    // stack port
    input wire logic stk_req,
    input wire logic stk_we,
    input wire logic [31:0] stk_addr,
    input wire logic [31:0] stk_wdata,
    output logic stk_ack,
    output logic [31:0] stk_rdata
);
    logic [31:0] mem [256];
    logic tick_q;
    logic [31:0] last_q;
    initial
    begin
        tick_q = 1'b0;
        last_q = 32'h0;
        foreach (mem[i]) mem[i] = 32'h0;
    end
    // slow pace acks every other cycle to stretch save and restore
    assign stk_ack = stk_req && (!slow || tick_q);
    // between acks the bus shows junk, never the last word
    assign stk_rdata = stk_ack ? mem[stk_addr[9:2]] : ~last_q;
    always @(posedge pclk)
    begin
        tick_q <= ~tick_q;
        if (stk_ack && stk_we)
            mem[stk_addr[9:2]] <= stk_wdata;
        if (stk_ack)
            last_q <= stk_rdata;
    end
endmodule

//--- dv/tb_evt_unit.sv
`timescale 1ns/10ps
`include "evt_unit_cfg.svh"
module tb_evt_unit;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, pc_out, sr_out, stk_addr, stk_wdata, stk_rdata, rd, pc, sr;
    logic pready, pslverr, perr, gl, op_ack, stall, pc_load, gpr_load, stk_req, stk_we, stk_ack;
    logic [4:0] crit = 5'h00;
    logic [3:0] int_req = 4'h0;
    logic [13:0] ivec = 14'h0000;
    logic [13:0] ofs_o = 14'h0008;
    logic [13:0] ofs_y = 14'h0020;
    logic exc_o = 1'b0, exc_y = 1'b0, scall = 1'b0, rete = 1'b0, rets = 1'b0, retd = 1'b0, dbg = 1'b0;
    logic slow = 1'b0;
    logic [9:0] ev_ack;
    logic [10:0] s;
    logic [31:0] dvec = 32'h0000_8800;
    logic [31:0] cpc = 32'h0000_3456;
    logic [31:0] gin [6] = '{32'h0000_00A8, 32'h0000_00A9, 32'h0000_00AA, 32'h0000_00AB, 32'h0000_00AC, 32'h0000_00AE};
    logic [31:0] gout [6];
    logic [2:0] bank;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    evt_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .unrec_req(crit[0]), .multihit_req(crit[1]), .bus_err_d_req(crit[2]), .bus_err_i_req(crit[3]),
        .nmi_req(crit[4]), .int_req(int_req), .ivec_offset(ivec), .exc_old_req(exc_o),
        .exc_old_offset(ofs_o), .exc_young_req(exc_y), .exc_young_offset(ofs_y), .ev_ack(ev_ack),
        .scall_req(scall), .rete_req(rete), .rets_req(rets), .retd_req(retd), .dbg_req(dbg),
        .dbg_vector(dvec), .ctx_pc(cpc), .gpr_in(gin), .op_ack(op_ack), .core_stall(stall),
        .pc_load(pc_load), .pc_out(pc_out), .gpr_load(gpr_load), .gpr_out(gout), .bank_sel(bank),
        .sr_out(sr_out), .stk_req(stk_req), .stk_we(stk_we), .stk_addr(stk_addr),
        .stk_wdata(stk_wdata), .stk_ack(stk_ack), .stk_rdata(stk_rdata));

    stack_mem u_stk (.pclk(pclk), .slow(slow), .stk_req(stk_req), .stk_we(stk_we), .stk_addr(stk_addr),
        .stk_wdata(stk_wdata), .stk_ack(stk_ack), .stk_rdata(stk_rdata));

    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic quiet();
        s = 11'h000;
        repeat (10)
        begin
            @(posedge pclk);
            s = s | {op_ack, ev_ack};
        end
    endtask

    // waits for the take, then the handler jump; b is the ack bit
    task automatic go(input int b);
        s = 11'h000;
        for (int n = 0; n < 60 && s === 11'h000; n++)
        begin
            @(posedge pclk);
            s = {op_ack, ev_ack};
        end
        crit <= 5'h00;
        int_req <= 4'h0;
        {exc_o, exc_y, scall, rete, rets, retd, dbg} <= 7'h00;
        chk({21'h0, s}, 32'h1 << b);
        for (int n = 0; n < 60 && pc_load !== 1'b1; n++)
            @(posedge pclk);
        pc = pc_out;
        gl = gpr_load;
        @(posedge pclk);
        sr = sr_out;
    endtask

    task automatic ret_chk(input logic [31:0] srx);
        rete <= 1'b1;
        go(10);
        chk(pc, cpc);
        chk(sr, srx);
    endtask

    task automatic t_regs();
        apb(1'b0, `OFS_SR, 32'h0);
        chk(rd, `SR_RST);
        apb(1'b1, `OFS_EVB, 32'h0000_1010);
        apb(1'b1, `OFS_SSP, 32'h0000_0400);
        apb(1'b0, `OFS_EVB, 32'h0);
        chk(rd, 32'h0000_1010);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, perr}, 32'h1);
    endtask

    // reset state has global and exception masks set
    task automatic t_crit();
        for (int i = 0; i < 5; i++)
        begin
            crit[i] <= 1'b1;
            go(i);
            chk(pc, 32'h0000_1010 | 32'(i * 4));
            chk(u_stk.mem[255], `SR_RST);
            chk(u_stk.mem[254], cpc);
            chk(sr & 32'h003F_0000, 32'h003F_0000);
            ret_chk(`SR_RST);
        end
        apb(1'b0, `OFS_SSP, 32'h0);
        chk(rd, 32'h0000_0400);
    endtask

    task automatic t_irq();
        slow <= 1'b1;
        apb(1'b1, `OFS_SR, 32'h01CC_0000);
        apb(1'b0, `OFS_SR, 32'h0);
        chk(rd, 32'h004C_0000);
        int_req <= 4'h6;
        ivec <= 14'h0204;
        quiet();
        chk({21'h0, s}, 32'h0);
        apb(1'b1, `OFS_SR, 32'h0);
        go(6);
        chk(pc, 32'h0000_1214);
        chk(u_stk.mem[253], gin[0]);
        chk(u_stk.mem[248], gin[5]);
        chk(sr, 32'h010E_0000);
        chk({29'h0, bank}, 32'h4);
        int_req <= 4'hA;
        ivec <= 14'h3FFC;
        go(5);
        chk(pc, 32'h0000_3FFC);
        ret_chk(32'h010E_0000);
        chk({31'h0, gl}, 32'h1);
        chk(gout[5], gin[5]);
        ret_chk(32'h0040_0000);
        slow <= 1'b0;
    endtask

    task automatic t_exc();
        exc_o <= 1'b1;
        exc_y <= 1'b1;
        go(9);
        chk(pc, 32'h0000_1018);
        chk(sr & 32'h0021_0000, 32'h0021_0000);
        chk({29'h0, bank}, 32'h6);
        ret_chk(32'h0040_0000);
        exc_y <= 1'b1;
        go(9);
        chk(pc, 32'h0000_1030);
        ret_chk(32'h0040_0000);
    endtask

    task automatic t_dbg();
        apb(1'b1, `OFS_SR, 32'h0400_0000);
        dbg <= 1'b1;
        quiet();
        chk({21'h0, s}, 32'h0);
        apb(1'b1, `OFS_SR, 32'h0);
        go(10);
        chk(pc, dvec);
        chk(sr & 32'h081E_0000, 32'h081E_0000);
        apb(1'b0, `OFS_DRAR, 32'h0);
        chk(rd, cpc);
        apb(1'b0, `OFS_SSP, 32'h0);
        chk(rd, 32'h0000_0400);
        apb(1'b1, `OFS_SR, 32'h0100_0000);
        apb(1'b0, `OFS_SR, 32'h0);
        chk(rd, 32'h0900_0000);
        chk({29'h0, bank}, 32'h4);
        retd <= 1'b1;
        go(10);
        chk(pc, cpc);
        chk(sr, 32'h0040_0000);
    endtask

    task automatic t_scall();
        scall <= 1'b1;
        go(10);
        chk(pc, 32'h0000_1110);
        chk(u_stk.mem[254], cpc);
        rets <= 1'b1;
        go(10);
        chk(pc, cpc);
        chk(sr, 32'h0040_0000);
    endtask

    // a hang costs a mismatch and ends the run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_crit();
        t_irq();
        t_exc();
        t_dbg();
        t_scall();
        conclude();
    end
endmodule
